// ### design/swp_defines.svh
// swp_defines.svh: offsets, fields, reset values and timings
// assumes: included by swp_top.sv and the bench, not by swp_pkg.sv; 125 MHz clock
`ifndef SWP_DEFINES_SVH
`define SWP_DEFINES_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define SWP_IDX_CLKMD   6'h03
`define SWP_IDX_PA_DATA 6'h04
`define SWP_IDX_PA_DIR  6'h05
`define SWP_IDX_PA_PU   6'h06
`define SWP_IDX_PA_DIER 6'h07
`define SWP_IDX_PB_DATA 6'h08
`define SWP_IDX_PB_DIR  6'h09
`define SWP_IDX_PB_PU   6'h0A
`define SWP_IDX_PB_DIER 6'h0B
`define SWP_IDX_MISC    6'h0C
`define SWP_IDX_TMR     6'h0D
`define SWP_IDX_SUSP    6'h0E
`define SWP_IDX_STAT    6'h0F

// ****************************************
// field positions and reset values
// ****************************************
`define SWP_CLKMD_WDT_EN  1
`define SWP_CLKMD_SLOW_EN 2
`define SWP_CLKMD_FAST_EN 4
`define SWP_MISC_FAST_WK  5
`define SWP_MISC_EXT_EN   6
`define SWP_TMR_RUN       7
`define SWP_CLKMD_RST     8'hF6
`define SWP_MISC_RST      8'h00
`define SWP_TMR_RST       8'h00
`define SWP_CMD_SAVE      8'h01
`define SWP_CMD_DOWN      8'h02
`define SWP_SRC_SYS       2'h0
`define SWP_SRC_FAST      2'h1
`define SWP_SRC_SLOW      2'h2
`define SWP_SRC_EXT       2'h3
`define SWP_TMR_BIT_BASE  4'h8

// ****************************************
// timing
// ****************************************
`define SWP_NORMAL_WAKE_TICKS 16'h0400
`define SWP_FAST_WAKE_TICKS   16'h0080
`define SWP_CLK_MHZ           125
`define SWP_FAST_STAB_NS      2000
`define SWP_SLOW_STAB_NS      8000

`endif

// ### design/swp_pkg.sv
// swp_pkg: types shared by the suspend and wake-up block
// assumes: nothing from swp_defines.svh; the package uses no macros
package swp_pkg;
  // suspend sequencer states, one-hot
  typedef enum logic [3:0] {
    SWP_ON   = 4'h1,
    SWP_SAVE = 4'h2,
    SWP_DOWN = 4'h4,
    SWP_WAKE = 4'h8
  } swp_state_t;
endpackage : swp_pkg

// ### design/swp_top.sv
// swp_top: suspend / wake-up sequencer with two 8-bit io ports
// assumes: osc ticks are one-cycle strobes on i_clk; pads are async
//
// Operation
// - power-save timer wake after 256 fast clocks when bit 8 selected
// - deep-sleep command enters power-down, stopping oscillators and memory
// - power-down keeps all data memory and registers unchanged
// - input pin with digital enable clear cannot wake
// - power-down wakes on pins only; power-save on pins or timer
// - normal wake resumes after 1024 slow oscillator periods
// - fast wake from power-save resumes after 128 system clocks
// - fast wake from power-down adds oscillator stabilisation time
// - external oscillator enabled forces 1024 slow periods wake
// - fast wake switches watchdog clock to system clock
// - pin wake continues with instruction after suspend
// - direction 0 input with pull-up bit; 1 drives data bit
// - pin driven low has pull-up off
// - port read gives pad for inputs, data register for outputs
// - open-drain pin only pulls low or releases
// - power-save gates system clock and program memory; oscillators keep running
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
`include "swp_defines.svh"
`default_nettype none

module swp_top
  import swp_pkg::*;
(
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // oscillator period strobes
  input  wire logic        i_sys_tick,
  input  wire logic        i_fast_tick,
  input  wire logic        i_slow_tick,
  input  wire logic        i_ext_tick,
  // port a pins
  input  wire logic [7:0]  i_pa_pad,
  output logic [7:0]       o_pa_out,
  output logic [7:0]       o_pa_oe,
  output logic [7:0]       o_pa_pullup,
  // port b pins
  input  wire logic [7:0]  i_pb_pad,
  output logic [7:0]       o_pb_out,
  output logic [7:0]       o_pb_oe,
  output logic [7:0]       o_pb_pullup,
  // power and clock controls
  output logic             o_sys_clk_en,
  output logic             o_fast_osc_en,
  output logic             o_slow_osc_en,
  output logic             o_ext_osc_en,
  output logic             o_prog_mem_en,
  output logic             o_wdt_clk_sys
);

  // ****************************************
  // constants
  // ****************************************
  localparam logic [15:0] FAST_STAB_CYC = 16'((`SWP_FAST_STAB_NS * `SWP_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] SLOW_STAB_CYC = 16'((`SWP_SLOW_STAB_NS * `SWP_CLK_MHZ + 999) / 1000);

  // ****************************************
  // helpers
  // ****************************************
  // pad level for inputs, data bit for outputs
  function automatic logic [7:0] port_rd(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] pad);
    port_rd = (dir & dat) | (~dir & pad);
  endfunction : port_rd

  // pull-up never on while driving low
  function automatic logic [7:0] pull_en(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] pu);
    pull_en = pu & ~(dir & ~dat);
  endfunction : pull_en

  // toggle on a digital input that may wake
  function automatic logic pin_wake(
    input logic [7:0] dir, input logic [7:0] dier, input logic [7:0] now, input logic [7:0] was);
    pin_wake = |((now ^ was) & ~dir & dier);
  endfunction : pin_wake

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************
  // pad synchronisers
  // ****************************************
  logic [7:0] pa_s1, pa_s2, pa_s3, pb_s1, pb_s2, pb_s3;

  // third stage only for toggle detection
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_s1 <= 8'h00;
      pa_s2 <= 8'h00;
      pa_s3 <= 8'h00;
      pb_s1 <= 8'h00;
      pb_s2 <= 8'h00;
      pb_s3 <= 8'h00;
    end else if (i_ce) begin
      pa_s1 <= i_pa_pad;
      pa_s2 <= pa_s1;
      pa_s3 <= pa_s2;
      pb_s1 <= i_pb_pad;
      pb_s2 <= pb_s1;
      pb_s3 <= pb_s2;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] clkmd, misc, tmr_cfg;
  logic [7:0] pa_data, pa_dir, pa_pu, pa_dier;
  logic [7:0] pb_data, pb_dir, pb_pu, pb_dier;
  logic       ack, req, wr_go;
  logic [5:0] idx;
  swp_state_t state;
  logic       fast_wk;

  assign req     = i_avs_read | i_avs_write;
  assign idx     = i_avs_address[7:2];
  assign wr_go   = i_avs_write & ack & (state == SWP_ON);
  assign fast_wk = misc[`SWP_MISC_FAST_WK] & ~misc[`SWP_MISC_EXT_EN];
  // one wait state, answer on the second edge
  assign o_avs_waitrequest = req & ~ack;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else if (i_ce) begin
      ack <= req & ~ack;
    end
  end

  // writes only while running; suspended contents stay put
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkmd   <= `SWP_CLKMD_RST;
      misc    <= `SWP_MISC_RST;
      pa_data <= 8'h00;
      pa_dir  <= 8'h00;
      pa_pu   <= 8'h00;
      pa_dier <= 8'hFF;
      pb_data <= 8'h00;
      pb_dir  <= 8'h00;
      pb_pu   <= 8'h00;
      pb_dier <= 8'hFF;
    end else if (i_ce && wr_go) begin
      case (idx)
        `SWP_IDX_CLKMD:   clkmd   <= i_avs_writedata[7:0];
        `SWP_IDX_MISC:    misc    <= i_avs_writedata[7:0];
        `SWP_IDX_PA_DATA: pa_data <= i_avs_writedata[7:0];
        `SWP_IDX_PA_DIR:  pa_dir  <= i_avs_writedata[7:0];
        `SWP_IDX_PA_PU:   pa_pu   <= i_avs_writedata[7:0];
        `SWP_IDX_PA_DIER: pa_dier <= i_avs_writedata[7:0];
        `SWP_IDX_PB_DATA: pb_data <= i_avs_writedata[7:0];
        `SWP_IDX_PB_DIR:  pb_dir  <= i_avs_writedata[7:0];
        `SWP_IDX_PB_PU:   pb_pu   <= i_avs_writedata[7:0];
        `SWP_IDX_PB_DIER: pb_dier <= i_avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // wake-capable timer
  // ****************************************
  logic [15:0] tmr_cnt;
  logic        tmr_tick, tmr_bit, tmr_bit_q;
  logic [3:0]  tmr_sel;

  assign tmr_sel = `SWP_TMR_BIT_BASE + {1'b0, tmr_cfg[2:0]};
  assign tmr_bit = tmr_cnt[tmr_sel];

  // sys source stalls while the system clock is gated
  always_comb begin
    case (tmr_cfg[4:3])
      `SWP_SRC_SYS:  tmr_tick = i_sys_tick & (state == SWP_ON);
      `SWP_SRC_FAST: tmr_tick = i_fast_tick & o_fast_osc_en;
      `SWP_SRC_SLOW: tmr_tick = i_slow_tick & o_slow_osc_en;
      default:       tmr_tick = i_ext_tick & o_ext_osc_en;
    endcase
  end

  // writing the config restarts the count from zero
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_cfg   <= `SWP_TMR_RST;
      tmr_cnt   <= 16'h0000;
      tmr_bit_q <= 1'b0;
    end else if (i_ce) begin
      tmr_bit_q <= tmr_bit;
      if (wr_go && idx == `SWP_IDX_TMR) begin
        tmr_cfg <= i_avs_writedata[7:0];
        tmr_cnt <= 16'h0000;
      end else if (tmr_cfg[`SWP_TMR_RUN] && tmr_tick) begin
        tmr_cnt <= tmr_cnt + 16'h0001;
      end
    end
  end

  // ****************************************
  // suspend sequencer
  // ****************************************
  logic        from_down, stab_done, pin_ev, tmr_ev;
  logic [15:0] wk_cnt;
  logic [1:0]  wake_cause;

  assign pin_ev = pin_wake(pa_dir, pa_dier, pa_s2, pa_s3) |
                  pin_wake(pb_dir, pb_dier, pb_s2, pb_s3);
  assign tmr_ev = tmr_bit & ~tmr_bit_q;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= SWP_ON;
      from_down  <= 1'b0;
      stab_done  <= 1'b0;
      wk_cnt     <= 16'h0000;
      wake_cause <= 2'h0;
    end else if (i_ce) begin
      case (state)
        SWP_ON: begin
          if (wr_go && idx == `SWP_IDX_SUSP) begin
            if (i_avs_writedata[7:0] == `SWP_CMD_DOWN) begin
              state     <= SWP_DOWN;
              from_down <= 1'b1;
            end else if (i_avs_writedata[7:0] == `SWP_CMD_SAVE) begin
              state     <= SWP_SAVE;
              from_down <= 1'b0;
            end
          end
        end
        SWP_SAVE: begin
          if (pin_ev || tmr_ev) begin
            state      <= SWP_WAKE;
            stab_done  <= 1'b1;
            wk_cnt     <= 16'h0000;
            wake_cause <= {tmr_ev & ~pin_ev, pin_ev};
          end
        end
        SWP_DOWN: begin
          if (pin_ev) begin
            state      <= SWP_WAKE;
            stab_done  <= ~fast_wk;
            wk_cnt     <= 16'h0000;
            wake_cause <= 2'h1;
          end
        end
        SWP_WAKE: begin
          // fast power-down wake: oscillator settle first, in i_clk cycles
          if (!stab_done) begin
            if (wk_cnt + 16'h0001 >= (clkmd[7:5] == 3'h7 ? SLOW_STAB_CYC : FAST_STAB_CYC)) begin
              stab_done <= 1'b1;
              wk_cnt    <= 16'h0000;
            end else begin
              wk_cnt <= wk_cnt + 16'h0001;
            end
          end else if (fast_wk ? i_sys_tick : i_slow_tick) begin
            if (wk_cnt + 16'h0001 >= (fast_wk ? `SWP_FAST_WAKE_TICKS : `SWP_NORMAL_WAKE_TICKS)) begin
              state <= SWP_ON;
            end else begin
              wk_cnt <= wk_cnt + 16'h0001;
            end
          end
        end
        default: state <= SWP_ON;
      endcase
    end
  end

  // ****************************************
  // power controls
  // ****************************************
  // only power-down stops oscillators; program memory is off whenever not running
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sys_clk_en  <= 1'b1;
      o_fast_osc_en <= 1'b0;
      o_slow_osc_en <= 1'b1;
      o_ext_osc_en  <= 1'b0;
      o_prog_mem_en <= 1'b1;
      o_wdt_clk_sys <= 1'b0;
    end else if (i_ce) begin
      o_sys_clk_en  <= (state == SWP_ON);
      o_fast_osc_en <= clkmd[`SWP_CLKMD_FAST_EN] & (state != SWP_DOWN);
      o_slow_osc_en <= clkmd[`SWP_CLKMD_SLOW_EN] & (state != SWP_DOWN);
      o_ext_osc_en  <= misc[`SWP_MISC_EXT_EN] & (state != SWP_DOWN);
      o_prog_mem_en <= (state == SWP_ON);
      o_wdt_clk_sys <= fast_wk;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // open-drain pin drives only a low level
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pa_out    <= 8'h00;
      o_pa_oe     <= 8'h00;
      o_pa_pullup <= 8'h00;
      o_pb_out    <= 8'h00;
      o_pb_oe     <= 8'h00;
      o_pb_pullup <= 8'h00;
    end else if (i_ce) begin
      o_pa_out        <= pa_data;
      o_pa_out[5]     <= 1'b0;
      o_pa_oe         <= pa_dir;
      o_pa_oe[5]      <= pa_dir[5] & ~pa_data[5];
      o_pa_pullup     <= pull_en(pa_dir, pa_data, pa_pu);
      o_pb_out        <= pb_data;
      o_pb_oe         <= pb_dir;
      o_pb_pullup     <= pull_en(pb_dir, pb_data, pb_pu);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // captured on the wait cycle, stands through the answer edge
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_ce && i_avs_read && !ack) begin
      case (idx)
        `SWP_IDX_CLKMD:   o_avs_readdata <= {24'h000000, clkmd};
        `SWP_IDX_MISC:    o_avs_readdata <= {24'h000000, misc};
        `SWP_IDX_TMR:     o_avs_readdata <= {24'h000000, tmr_cfg};
        `SWP_IDX_PA_DATA: o_avs_readdata <= {24'h000000, port_rd(pa_dir, pa_data, pa_s2)};
        `SWP_IDX_PA_DIR:  o_avs_readdata <= {24'h000000, pa_dir};
        `SWP_IDX_PA_PU:   o_avs_readdata <= {24'h000000, pa_pu};
        `SWP_IDX_PA_DIER: o_avs_readdata <= {24'h000000, pa_dier};
        `SWP_IDX_PB_DATA: o_avs_readdata <= {24'h000000, port_rd(pb_dir, pb_data, pb_s2)};
        `SWP_IDX_PB_DIR:  o_avs_readdata <= {24'h000000, pb_dir};
        `SWP_IDX_PB_PU:   o_avs_readdata <= {24'h000000, pb_pu};
        `SWP_IDX_PB_DIER: o_avs_readdata <= {24'h000000, pb_dier};
        `SWP_IDX_STAT:    o_avs_readdata <= {16'h0000, tmr_cnt[7:0], o_wdt_clk_sys, from_down, wake_cause, state};
        default:          o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule : swp_top

`default_nettype wire

// ### tb/swp_pads.sv
// swp_pads: outside circuitry on one 8-bit port
// assumes: pads resolved from design enables and bench drive
`timescale 1ns/1ns
`default_nettype none
module swp_pads (
  // clock and design side
  input  wire logic       i_clk,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_pu,
  // bench side
  input  wire logic [7:0] i_drv,
  input  wire logic [7:0] i_val,
  output logic [7:0]      o_pad
);
  logic [7:0] last;
  // undriven pin without pull-up wanders, so a stale level never passes
  always_comb o_pad = (i_oe & i_out) | (~i_oe & i_drv & i_val) | (~i_oe & ~i_drv & (i_pu | ~last));
  // previous level for the floating case
  always_ff @(posedge i_clk) last <= o_pad;
endmodule : swp_pads
`default_nettype wire

// ### tb/swp_top_asserts.sv
// swp_top_asserts: port-level checks on the suspend and pin block
// assumes: one clock domain, bound onto every swp_top instance
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// checker
// ****************************************
module swp_top_asserts (
  // clock, reset, bus
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_ce,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  // pins
  input wire logic [7:0] o_pa_out,
  input wire logic [7:0] o_pa_oe,
  input wire logic [7:0] o_pa_pullup,
  input wire logic [7:0] o_pb_out,
  input wire logic [7:0] o_pb_oe,
  input wire logic [7:0] o_pb_pullup,
  // power controls
  input wire logic       o_sys_clk_en,
  input wire logic       o_fast_osc_en,
  input wire logic       o_slow_osc_en,
  input wire logic       o_ext_osc_en,
  input wire logic       o_prog_mem_en,
  input wire logic       o_wdt_clk_sys
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // one wait cycle per access
  a_bus_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce
    |=> !o_avs_waitrequest) else $error("bus answer late");
  // slow osc falling while halted marks power-down entry
  a_down_all_off: assert property ($fell(o_slow_osc_en) && !o_prog_mem_en
    |-> !o_fast_osc_en && !o_ext_osc_en && !o_sys_clk_en) else $error("osc left on in power-down");
  a_save_osc_kept: assert property (!o_sys_clk_en && o_slow_osc_en && $past(o_slow_osc_en)
    |-> $stable(o_fast_osc_en) && $stable(o_ext_osc_en)) else $error("osc changed in power-save");
  a_halt_pins_kept: assert property (!o_sys_clk_en && !$past(o_sys_clk_en)
    |-> $stable(o_pa_out) && $stable(o_pa_oe) && $stable(o_pb_out) && $stable(o_pb_oe) && $stable(o_pa_pullup))
    else $error("pin state changed while halted");
  a_low_no_pullup: assert property ((o_pa_pullup & o_pa_oe & ~o_pa_out) == 8'h00
    && (o_pb_pullup & o_pb_oe & ~o_pb_out) == 8'h00) else $error("pull-up on driven-low pin");
  a_odrain_no_high: assert property (o_pa_oe[5] |-> !o_pa_out[5]) else $error("open-drain drove high");
  a_wake_min_count: assert property ($rose(o_sys_clk_en) |-> $past(o_sys_clk_en, 128) == 1'b0)
    else $error("resumed too soon");
  a_ext_no_fast: assert property (o_sys_clk_en && o_ext_osc_en |-> !o_wdt_clk_sys)
    else $error("fast wake with ext osc");
endmodule : swp_top_asserts

bind swp_top swp_top_asserts u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_pa_out(o_pa_out), .o_pa_oe(o_pa_oe), .o_pa_pullup(o_pa_pullup),
  .o_pb_out(o_pb_out), .o_pb_oe(o_pb_oe), .o_pb_pullup(o_pb_pullup), .o_sys_clk_en(o_sys_clk_en),
  .o_fast_osc_en(o_fast_osc_en), .o_slow_osc_en(o_slow_osc_en), .o_ext_osc_en(o_ext_osc_en),
  .o_prog_mem_en(o_prog_mem_en), .o_wdt_clk_sys(o_wdt_clk_sys));
`default_nettype wire

// ### tb/swp_top_bench.sv
// swp_top_bench: register-level test of suspend, wake and pins
// assumes: swp_top, swp_pads and the checker compiled before it
`timescale 1ns/1ns
`include "swp_defines.svh"
`default_nettype none
module swp_top_bench;
  import swp_pkg::*;
  logic        clk, ce, rst_n, rd, wr, wreq, sys_en, fast_en, slow_en, ext_en, mem_en, wdt_sys, tk_slow, tk_ext;
  logic [7:0]  adr, pa_val, pa_pad, pb_pad, pa_out, pa_oe, pa_pu, pb_out, pb_oe, pb_pu;
  logic [31:0] wd, rdata, rd_data;
  logic [1:0]  cyc;
  int          failures, num_checks, n;
  // design, pins tied to the outside model
  swp_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rd_data), .o_avs_waitrequest(wreq),
    .i_sys_tick(1'b1), .i_fast_tick(1'b1), .i_slow_tick(tk_slow), .i_ext_tick(tk_ext), .i_pa_pad(pa_pad),
    .o_pa_out(pa_out), .o_pa_oe(pa_oe), .o_pa_pullup(pa_pu), .i_pb_pad(pb_pad), .o_pb_out(pb_out),
    .o_pb_oe(pb_oe), .o_pb_pullup(pb_pu), .o_sys_clk_en(sys_en), .o_fast_osc_en(fast_en),
    .o_slow_osc_en(slow_en), .o_ext_osc_en(ext_en), .o_prog_mem_en(mem_en), .o_wdt_clk_sys(wdt_sys));
  swp_pads u_pa (.i_clk(clk), .i_oe(pa_oe), .i_out(pa_out), .i_pu(pa_pu), .i_drv(8'hFF), .i_val(pa_val),
    .o_pad(pa_pad));
  swp_pads u_pb (.i_clk(clk), .i_oe(pb_oe), .i_out(pb_out), .i_pu(pb_pu), .i_drv(8'hFF), .i_val(8'h3C),
    .o_pad(pb_pad));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // slow strobe every 4th cycle keeps normal wakes short
  always @(posedge clk) begin
    cyc     <= cyc + 2'h1;
    tk_slow <= (cyc == 2'h3);
    tk_ext  <= cyc[0];
  end
  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus access, held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [5:0] idx, input logic [7:0] d);
    int k;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= {idx, 2'h0};
    wd <= {24'h000000, d};
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    @(posedge clk);
    rdata = rd_data;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      failures++;
      print_verdict();
    end
  endtask : acc
  // flip pad bits, count cycles until the system clock is back
  task automatic wake(input logic [7:0] tog);
    repeat (3) @(posedge clk);
    pa_val <= pa_val ^ tog;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (sys_en !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      failures++;
      print_verdict();
    end
  endtask : wake
  // main sequence
  initial begin
    rst_n = 1'b0;
    {rd, wr, adr, wd, cyc, tk_slow, tk_ext} = '0;
    pa_val = 8'hA0;
    ce = 1'b1;
    failures = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(0, `SWP_IDX_MISC, 8'h00);
    chk(rdata, 32'h00000000);
    acc(0, 6'h3F, 8'h00);
    chk(rdata, 32'h00000000);
    acc(0, `SWP_IDX_PB_DATA, 8'h00);
    chk(rdata, 32'h0000003C);
    acc(1, `SWP_IDX_PA_DIR, 8'h2F);
    acc(1, `SWP_IDX_PA_DATA, 8'h25);
    acc(1, `SWP_IDX_PA_PU, 8'hFF);
    acc(0, `SWP_IDX_PA_DATA, 8'h00);
    chk(rdata, 32'h000000A5);
    chk({pa_oe, pa_out, pa_pu}, 32'h000F05F5);
    acc(1, `SWP_IDX_PA_DATA, 8'h05);
    repeat (2) @(negedge clk);
    chk({pa_oe, pa_out}, 32'h00002F05);
    acc(1, `SWP_IDX_PA_DIR, 8'h00);
    acc(1, `SWP_IDX_PA_DIER, 8'hFE);
    acc(1, `SWP_IDX_PB_DIER, 8'hFF);
    acc(1, `SWP_IDX_PB_DIR, 8'h0F);
    acc(1, `SWP_IDX_PB_DATA, 8'h05);
    acc(1, `SWP_IDX_PB_PU, 8'hFF);
    acc(0, `SWP_IDX_PB_DATA, 8'h00);
    chk(rdata, 32'h00000035);
    chk({pb_oe, pb_out, pb_pu}, 32'h000F05F5);
    acc(1, `SWP_IDX_PB_DIR, 8'h00);
    acc(0, `SWP_IDX_CLKMD, 8'h00);
    chk(rdata, 32'h000000F6);
    acc(1, `SWP_IDX_SUSP, `SWP_CMD_DOWN);
    acc(0, `SWP_IDX_STAT, 8'h00);
    chk({rdata[3:0], mem_en, slow_en, fast_en}, 32'h00000020);
    acc(1, `SWP_IDX_CLKMD, 8'h00);
    pa_val <= pa_val ^ 8'h01;
    repeat (300) @(negedge clk);
    chk(sys_en, 1'b0);
    wake(8'h02);
    chk(n >= 4080 && n <= 4120, 1'b1);
    acc(0, `SWP_IDX_STAT, 8'h00);
    chk(rdata & 32'h7F, 32'h00000051);
    acc(0, `SWP_IDX_CLKMD, 8'h00);
    chk(rdata, 32'h000000F6);
    acc(1, `SWP_IDX_TMR, 8'h88);
    acc(1, `SWP_IDX_SUSP, `SWP_CMD_SAVE);
    wake(8'h00);
    chk(n >= 4300 && n <= 4400, 1'b1);
    acc(0, `SWP_IDX_STAT, 8'h00);
    chk(rdata & 32'h7F, 32'h00000021);
    acc(1, `SWP_IDX_TMR, 8'h00);
    acc(1, `SWP_IDX_MISC, 8'h20);
    repeat (2) @(negedge clk);
    chk(wdt_sys, 1'b1);
    acc(1, `SWP_IDX_SUSP, `SWP_CMD_SAVE);
    wake(8'h04);
    chk(n >= 128 && n <= 140, 1'b1);
    acc(1, `SWP_IDX_SUSP, `SWP_CMD_DOWN);
    wake(8'h08);
    chk(n >= 1128 && n <= 1145, 1'b1);
    acc(1, `SWP_IDX_MISC, 8'h60);
    repeat (2) @(negedge clk);
    chk({wdt_sys, ext_en}, 32'h00000001);
    acc(1, `SWP_IDX_SUSP, `SWP_CMD_SAVE);
    repeat (3) @(negedge clk);
    chk({sys_en, fast_en, ext_en}, 32'h00000003);
    // frozen clock enable must hold off the pin wake
    @(posedge clk);
    ce     <= 1'b0;
    pa_val <= pa_val ^ 8'h10;
    repeat (20) @(posedge clk);
    chk(sys_en, 1'b0);
    ce <= 1'b1;
    wake(8'h00);
    chk(n >= 4080 && n <= 4120, 1'b1);
    print_verdict();
  end
endmodule : swp_top_bench
`default_nettype wire
